//--- rtl/flash_sector_pkg.sv
// Shared constants and types for the flash sector access front end.
// Assumes a single 250 MHz clock shared with the host bus logic.
package flash_sector_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int CLK_NS = 4;
    localparam int GAP_US = 80;
    localparam int GAP_CYCLES = GAP_US * CLK_MHZ;
    localparam int PROG_NS = 400;
    localparam int PROG_CYCLES = PROG_NS / CLK_NS;

    // ----------------------------------------
    // Organisation
    // ----------------------------------------
    localparam int MAIN_SECTORS = 8;
    localparam int BOOT_SECTORS = 4;
    localparam int ALL_SECTORS = MAIN_SECTORS + BOOT_SECTORS;
    localparam int TERMS = 3;
    localparam int MAIN_AW = 14;
    localparam int BOOT_AW = 13;

    // ----------------------------------------
    // Register window
    // ----------------------------------------
    localparam logic [7:0] OFS_MAIN_PROT = 8'hc0;
    localparam logic [7:0] OFS_BOOT_PROT = 8'hc2;
    localparam int SECURITY_BIT = 7;
    localparam logic [7:0] REG_UNMAPPED = 8'h00;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // ----------------------------------------
    // Command bytes and addresses
    // ----------------------------------------
    localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
    localparam logic [11:0] UNLOCK_ADDR2 = 12'haaa;
    localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [1:0] ID_OFS = 2'h1;
    localparam logic [1:0] PROT_OFS = 2'h2;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic en;
        logic [15:0] match;
        logic [15:0] care;
    } term_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef enum logic [3:0] {
        S_READ = 4'h0,
        S_UNLK1 = 4'h1,
        S_UNLK2 = 4'h2,
        S_ERASE_ARM = 4'h3,
        S_PROG_DATA = 4'h4,
        S_PROG = 4'h5,
        S_COLLECT = 4'h6,
        S_ERASE = 4'h7,
        S_SUSP = 4'h8,
        S_ID = 4'h9
    } seq_state_t;

endpackage : flash_sector_pkg

//--- rtl/flash_sector_access.sv
// Flash sector access front end: select decode, array reads, command sequencer,
// program/erase engine, protection registers and ready/busy pin.
// Assumes the host bus request arrives as one-cycle strobes on mclk_i.
`timescale 1ns/1ns

// Behaviour
// - Main array split into eight selected sectors
// - Boot array: four 8KB individually selected sectors
// - Per-sector protection blocks program and erase
// - Erase whole sectors, program single bytes
// - Erase suspend serves other sectors, resume continues
// - Ready/busy pin low while program/erase runs
// - Ready/busy pin high when idle
// - Each select ORs up to three terms
// - Decode array generates all memory selects
// - Plain reads return array data
// - Plain writes never change flash
// - Commands return protection status and identifier
// - 256-byte register window at chosen base
// - Main protection status read-only at C0
// - Boot protection and security at C2
// - Commands other than suspend, resume and reset start with two unlock writes
// - Bad byte or gap timeout aborts sequence
// - Read-array mode after reset
module flash_sector_access #(
    parameter int MAIN_AW = flash_sector_pkg::MAIN_AW,
    parameter int BOOT_AW = flash_sector_pkg::BOOT_AW,
    parameter int GAP_CYCLES = flash_sector_pkg::GAP_CYCLES,
    parameter int PROG_CYCLES = flash_sector_pkg::PROG_CYCLES,
    parameter logic [7:0] DEVICE_ID = 8'h5a // Arbitrary value
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    input flash_sector_pkg::bus_req_t bus_i,
    input flash_sector_pkg::term_t main_terms_i [flash_sector_pkg::MAIN_SECTORS*flash_sector_pkg::TERMS],
    input flash_sector_pkg::term_t boot_terms_i [flash_sector_pkg::BOOT_SECTORS*flash_sector_pkg::TERMS],
    input flash_sector_pkg::term_t window_term_i,
    input wire logic [7:0] main_protect_i,
    input wire logic [3:0] boot_protect_i,
    input wire logic security_i,
    input wire logic status_pin_en_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [7:0] main_sector_select_o,
    output logic [3:0] boot_sector_select_o,
    output logic register_window_select_o,
    output logic port_c_pin_three_o,
    output logic port_c_pin_three_oe_n_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    localparam int GW = $clog2(GAP_CYCLES + 1);
    localparam int PW = $clog2(PROG_CYCLES + 1);

    function automatic logic term_hit(input flash_sector_pkg::term_t t, input logic [15:0] a);
        return t.en && ((a & t.care) == (t.match & t.care));
    endfunction : term_hit

    function automatic logic [3:0] lowest_set(input logic [11:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 11; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : lowest_set

    function automatic logic cmd_at(input logic [7:0] d, input logic [11:0] a,
                                    input logic [7:0] c, input logic [11:0] ca);
        return (d == c) && (a == ca);
    endfunction : cmd_at

    // ----------------------------------------
    // Select decode
    // ----------------------------------------
    logic [7:0] main_sel;
    logic [3:0] boot_sel;
    logic win_sel;

    always_comb begin
        main_sel = 8'h00;
        boot_sel = 4'h0;
        for (int s = 0; s < flash_sector_pkg::MAIN_SECTORS; s++) begin
            for (int t = 0; t < flash_sector_pkg::TERMS; t++) begin
                main_sel[s] = main_sel[s] | term_hit(main_terms_i[s*3+t], bus_i.addr);
            end
        end
        for (int s = 0; s < flash_sector_pkg::BOOT_SECTORS; s++) begin
            for (int t = 0; t < flash_sector_pkg::TERMS; t++) begin
                boot_sel[s] = boot_sel[s] | term_hit(boot_terms_i[s*3+t], bus_i.addr);
            end
        end
        win_sel = term_hit(window_term_i, bus_i.addr);
    end

    // Main wins over boot if both decode, so a bad map never writes two arrays
    logic flash_sel;
    logic [3:0] cur_sect;
    logic [11:0] prot;
    logic cur_prot;

    assign flash_sel = (|main_sel) | (|boot_sel);
    assign cur_sect = (|main_sel) ? lowest_set({4'h0, main_sel}) : lowest_set({boot_sel, 8'h00});
    assign prot = {boot_protect_i, main_protect_i};
    assign cur_prot = prot[cur_sect];

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            main_sector_select_o <= 8'h00;
            boot_sector_select_o <= 4'h0;
            register_window_select_o <= 1'b0;
        end else begin
            main_sector_select_o <= main_sel;
            boot_sector_select_o <= boot_sel;
            register_window_select_o <= win_sel;
        end
    end

    // ----------------------------------------
    // Arrays
    // ----------------------------------------
    logic [7:0] main_mem [flash_sector_pkg::MAIN_SECTORS << MAIN_AW];
    logic [7:0] boot_mem [flash_sector_pkg::BOOT_SECTORS << BOOT_AW];
    logic [7:0] rd_byte;

    assign rd_byte = cur_sect[3] ? boot_mem[{cur_sect[1:0], bus_i.addr[BOOT_AW-1:0]}]
                                 : main_mem[{cur_sect[2:0], bus_i.addr[MAIN_AW-1:0]}];

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    flash_sector_pkg::seq_state_t state;
    flash_sector_pkg::seq_state_t next_state;
    logic [GW-1:0] gap_ctr;
    logic [PW-1:0] prog_ctr;
    logic [MAIN_AW-1:0] erase_ctr;
    logic [11:0] pending;
    logic [11:0] next_pending;
    logic erase_armed;
    logic wr_hit;
    logic timeout;
    logic [7:0] d;
    logic [11:0] a;
    logic [3:0] erase_sect;
    logic erase_last;
    logic [11:0] bulk_mask;
    logic busy;

    assign wr_hit = bus_i.wr & flash_sel;
    assign d = bus_i.wdata;
    assign a = bus_i.addr[11:0];
    assign timeout = (gap_ctr == GW'(GAP_CYCLES));
    assign erase_sect = lowest_set(pending);
    assign erase_last = erase_sect[3] ? (&erase_ctr[BOOT_AW-1:0]) : (&erase_ctr);
    assign bulk_mask = (cur_sect[3] ? 12'hf00 : 12'h0ff) & ~prot;
    assign busy = (state == flash_sector_pkg::S_PROG) || (state == flash_sector_pkg::S_ERASE)
                  || (state == flash_sector_pkg::S_COLLECT);

    always_comb begin
        next_state = state;
        unique case (state)
            flash_sector_pkg::S_READ: begin
                if (wr_hit && cmd_at(d, a, flash_sector_pkg::CMD_UNLOCK1,
                                     flash_sector_pkg::UNLOCK_ADDR1)) begin
                    next_state = flash_sector_pkg::S_UNLK1;
                end
            end
            flash_sector_pkg::S_UNLK1: begin
                if (timeout) begin
                    next_state = flash_sector_pkg::S_READ;
                end else if (wr_hit) begin
                    next_state = cmd_at(d, a, flash_sector_pkg::CMD_UNLOCK2,
                                        flash_sector_pkg::UNLOCK_ADDR2)
                                 ? flash_sector_pkg::S_UNLK2 : flash_sector_pkg::S_READ;
                end
            end
            flash_sector_pkg::S_UNLK2: begin
                next_state = timeout ? flash_sector_pkg::S_READ : state;
                if (!timeout && wr_hit) begin
                    next_state = flash_sector_pkg::S_READ;
                    if (erase_armed) begin
                        if (d == flash_sector_pkg::CMD_SECTOR_ERASE) begin
                            next_state = flash_sector_pkg::S_COLLECT;
                        end else if (cmd_at(d, a, flash_sector_pkg::CMD_BULK_ERASE,
                                            flash_sector_pkg::UNLOCK_ADDR1) && |bulk_mask) begin
                            next_state = flash_sector_pkg::S_ERASE;
                        end
                    end else if (a == flash_sector_pkg::UNLOCK_ADDR1) begin
                        if (d == flash_sector_pkg::CMD_AUTOSEL) begin
                            next_state = flash_sector_pkg::S_ID;
                        end else if (d == flash_sector_pkg::CMD_PROGRAM) begin
                            next_state = flash_sector_pkg::S_PROG_DATA;
                        end else if (d == flash_sector_pkg::CMD_ERASE_SETUP) begin
                            next_state = flash_sector_pkg::S_ERASE_ARM;
                        end
                    end
                end
            end
            flash_sector_pkg::S_ERASE_ARM: begin
                if (timeout) begin
                    next_state = flash_sector_pkg::S_READ;
                end else if (wr_hit) begin
                    next_state = cmd_at(d, a, flash_sector_pkg::CMD_UNLOCK1,
                                        flash_sector_pkg::UNLOCK_ADDR1)
                                 ? flash_sector_pkg::S_UNLK1 : flash_sector_pkg::S_READ;
                end
            end
            flash_sector_pkg::S_PROG_DATA: begin
                if (timeout) begin
                    next_state = flash_sector_pkg::S_READ;
                end else if (wr_hit) begin
                    next_state = cur_prot ? flash_sector_pkg::S_READ : flash_sector_pkg::S_PROG;
                end
            end
            flash_sector_pkg::S_PROG: begin
                if (prog_ctr == '0) begin
                    next_state = flash_sector_pkg::S_READ;
                end
            end
            flash_sector_pkg::S_COLLECT: begin
                if (wr_hit) begin
                    next_state = (d == flash_sector_pkg::CMD_SECTOR_ERASE)
                                 ? state : flash_sector_pkg::S_READ;
                end else if (timeout) begin
                    next_state = (|pending) ? flash_sector_pkg::S_ERASE : flash_sector_pkg::S_READ;
                end
            end
            flash_sector_pkg::S_ERASE: begin
                if (wr_hit && d == flash_sector_pkg::CMD_SUSPEND) begin
                    next_state = flash_sector_pkg::S_SUSP;
                end else if (erase_last && (pending & ~(12'h001 << erase_sect)) == 12'h000) begin
                    next_state = flash_sector_pkg::S_READ;
                end
            end
            flash_sector_pkg::S_SUSP: begin
                if (wr_hit && d == flash_sector_pkg::CMD_SECTOR_ERASE) begin
                    next_state = flash_sector_pkg::S_ERASE;
                end
            end
            flash_sector_pkg::S_ID: begin
                if (wr_hit && d == flash_sector_pkg::CMD_RESET) begin
                    next_state = flash_sector_pkg::S_READ;
                end
            end
            default: next_state = flash_sector_pkg::S_READ;
        endcase
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= flash_sector_pkg::S_READ;
        end else begin
            state <= next_state;
        end
    end

    // Second unlock pair after the setup byte arms the erase commands
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            erase_armed <= 1'b0;
        end else if (state == flash_sector_pkg::S_ERASE_ARM
                     && next_state == flash_sector_pkg::S_UNLK1) begin
            erase_armed <= 1'b1;
        end else if (next_state == flash_sector_pkg::S_READ
                     || next_state == flash_sector_pkg::S_COLLECT
                     || next_state == flash_sector_pkg::S_ERASE) begin
            erase_armed <= 1'b0;
        end
    end

    // Gap timer restarts on every accepted byte
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            gap_ctr <= '0;
        end else if (wr_hit || next_state != state) begin
            gap_ctr <= '0;
        end else if (!timeout) begin
            gap_ctr <= gap_ctr + GW'(1);
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            prog_ctr <= '0;
        end else if (next_state == flash_sector_pkg::S_PROG && state != flash_sector_pkg::S_PROG) begin
            prog_ctr <= PW'(PROG_CYCLES - 1);
        end else if (prog_ctr != '0) begin
            prog_ctr <= prog_ctr - PW'(1);
        end
    end

    // ----------------------------------------
    // Erase bookkeeping
    // ----------------------------------------
    always_comb begin
        next_pending = pending;
        if (state == flash_sector_pkg::S_ERASE && erase_last) begin
            next_pending[erase_sect] = 1'b0;
        end
        if (wr_hit && d == flash_sector_pkg::CMD_SECTOR_ERASE && !cur_prot
            && next_state == flash_sector_pkg::S_COLLECT) begin
            next_pending[cur_sect] = 1'b1;
        end
        if (state == flash_sector_pkg::S_UNLK2 && next_state == flash_sector_pkg::S_ERASE) begin
            next_pending = bulk_mask;
        end
        if (state == flash_sector_pkg::S_COLLECT && next_state == flash_sector_pkg::S_READ) begin
            next_pending = 12'h000;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            pending <= 12'h000;
        end else begin
            pending <= next_pending;
        end
    end

    // Counter holds its place across a suspend so the resume picks up there
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            erase_ctr <= '0;
        end else if (state == flash_sector_pkg::S_ERASE && next_state != flash_sector_pkg::S_SUSP) begin
            erase_ctr <= erase_last ? '0 : erase_ctr + MAIN_AW'(1);
        end
    end

    // ----------------------------------------
    // Array write port
    // ----------------------------------------
    // Flash changes only here; no path from a plain host write reaches it
    always_ff @(posedge mclk_i) begin
        if (state == flash_sector_pkg::S_PROG_DATA && next_state == flash_sector_pkg::S_PROG) begin
            if (cur_sect[3]) begin
                boot_mem[{cur_sect[1:0], bus_i.addr[BOOT_AW-1:0]}] <= d;
            end else begin
                main_mem[{cur_sect[2:0], bus_i.addr[MAIN_AW-1:0]}] <= d;
            end
        end else if (state == flash_sector_pkg::S_ERASE && next_state != flash_sector_pkg::S_SUSP) begin
            if (erase_sect[3]) begin
                boot_mem[{erase_sect[1:0], erase_ctr[BOOT_AW-1:0]}] <= flash_sector_pkg::ERASED_BYTE;
            end else begin
                main_mem[{erase_sect[2:0], erase_ctr}] <= flash_sector_pkg::ERASED_BYTE;
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [7:0] prog_data;
    logic toggle;
    logic status_read;
    logic [7:0] status_byte;
    logic [7:0] id_byte;

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            prog_data <= 8'h00;
        end else if (state == flash_sector_pkg::S_PROG_DATA && wr_hit) begin
            prog_data <= d;
        end
    end

    // During suspend only the sectors waiting for erase report status
    assign status_read = busy || (state == flash_sector_pkg::S_SUSP && pending[cur_sect]);
    assign status_byte = {(state == flash_sector_pkg::S_PROG) ? ~prog_data[7] : 1'b0,
                          toggle, 6'h00};
    assign id_byte = (bus_i.addr[1:0] == flash_sector_pkg::ID_OFS) ? DEVICE_ID
                   : (bus_i.addr[1:0] == flash_sector_pkg::PROT_OFS) ? {7'h00, cur_prot}
                   : 8'h00;

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            toggle <= 1'b0;
        end else if (bus_i.rd && !win_sel && flash_sel && status_read) begin
            toggle <= ~toggle;
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= flash_sector_pkg::RDATA_RESET;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= bus_i.rd;
            if (bus_i.rd) begin
                if (win_sel) begin
                    if (bus_i.addr[7:0] == flash_sector_pkg::OFS_MAIN_PROT) begin
                        rdata_o <= main_protect_i;
                    end else if (bus_i.addr[7:0] == flash_sector_pkg::OFS_BOOT_PROT) begin
                        rdata_o <= 8'(security_i) << flash_sector_pkg::SECURITY_BIT
                                   | {4'h0, boot_protect_i};
                    end else begin
                        rdata_o <= flash_sector_pkg::REG_UNMAPPED;
                    end
                end else if (!flash_sel) begin
                    rdata_o <= flash_sector_pkg::REG_UNMAPPED;
                end else if (status_read) begin
                    rdata_o <= status_byte;
                end else if (state == flash_sector_pkg::S_ID) begin
                    rdata_o <= id_byte;
                end else begin
                    rdata_o <= rd_byte;
                end
            end
        end
    end

    // ----------------------------------------
    // Ready/busy pin
    // ----------------------------------------
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            port_c_pin_three_o <= 1'b1;
            port_c_pin_three_oe_n_o <= 1'b1;
        end else begin
            port_c_pin_three_o <= ~busy;
            port_c_pin_three_oe_n_o <= ~status_pin_en_i;
        end
    end

endmodule : flash_sector_access

//--- bench/flash_host_model.sv
// Host side of the byte bus: writes, reads and a ready wait.
// Assumes one request per two cycles and reads answered one cycle later.
`timescale 1ns/1ns
module flash_host_model (
    input logic mclk_i,
    input logic [7:0] rdata_i,
    input logic rvalid_i,
    input logic ready_i,
    output flash_sector_pkg::bus_req_t bus_o
);
    initial bus_o = '0;
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge mclk_i);
        bus_o = '{1'b0, 1'b1, a, v};
        @(negedge mclk_i);
        bus_o.wr = 1'b0;
        bus_o.wdata = ~v; // Stale data must not look valid
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(negedge mclk_i);
        bus_o = '{1'b1, 1'b0, a, 8'h00};
        @(negedge mclk_i);
        bus_o.rd = 1'b0;
        v = rvalid_i ? rdata_i : 8'hxx;
    endtask : rd
    task automatic wait_ready(output logic ok);
        ok = 1'b0;
        repeat (2) @(negedge mclk_i); // Pin is registered, busy shows late
        for (int i = 0; i < 400 && !ok; i++) begin
            @(negedge mclk_i);
            ok = ready_i;
        end
    endtask : wait_ready
endmodule : flash_host_model

//--- bench/flash_sector_access_asserts.sv
// Checker bound to the flash front end top module.
// Assumes PROG_CYCLES of at least 3.
`timescale 1ns/1ns
module flash_sector_access_asserts (
    input logic mclk_i,
    input logic reset_i,
    input flash_sector_pkg::bus_req_t bus_i,
    input logic [7:0] main_protect_i,
    input logic status_pin_en_i,
    input logic [7:0] rdata_o,
    input logic rvalid_o,
    input logic register_window_select_o,
    input logic port_c_pin_three_o,
    input logic port_c_pin_three_oe_n_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    a_read_answer: assert property (bus_i.rd |=> rvalid_o)
        else $error("no answer");
    a_no_stray: assert property (!bus_i.rd |=> !rvalid_o)
        else $error("stray valid");
    a_rdata_hold: assert property (!rvalid_o |-> $stable(rdata_o))
        else $error("data moved");
    a_main_prot: assert property (bus_i.rd && bus_i.addr[7:0] == 8'hc0 |=>
        register_window_select_o |-> rdata_o == $past(main_protect_i)) else $error("bad c0");
    a_pin_drive: assert property ($rose(status_pin_en_i) |=> !port_c_pin_three_oe_n_o)
        else $error("pin undriven");
    a_busy_cause: assert property ($fell(port_c_pin_three_o) |-> $past(bus_i.wr)
        || $past(bus_i.wr, 2)) else $error("busy uncaused");
    a_busy_len: assert property ($fell(port_c_pin_three_o) |-> !port_c_pin_three_o [*3])
        else $error("busy short");
    a_ready_reset: assert property ($fell(reset_i) |-> port_c_pin_three_o)
        else $error("not ready");
    c_window: cover property (rvalid_o && register_window_select_o);
    c_busy: cover property ($fell(port_c_pin_three_o));
    c_ready: cover property ($rose(port_c_pin_three_o));
endmodule : flash_sector_access_asserts

bind flash_sector_access flash_sector_access_asserts u_chk (.mclk_i, .reset_i, .bus_i,
    .main_protect_i, .status_pin_en_i, .rdata_o, .rvalid_o, .register_window_select_o,
    .port_c_pin_three_o, .port_c_pin_three_oe_n_o);

//--- bench/flash_sector_access_tb.sv
// Bench: host model drives the bus, answers are judged here.
// Assumes 16-byte main sectors and a 40-cycle byte gap.
`timescale 1ns/1ns
module flash_sector_access_tb;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary value
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic en = 1'b0;
    logic sec = 1'b1;
    logic vld, pin, oe_n, ok;
    logic [7:0] rdat, d, msel;
    logic [7:0] mp = 8'h40;
    logic [3:0] bsel;
    flash_sector_pkg::bus_req_t bus;
    flash_sector_pkg::term_t mt [24];
    flash_sector_pkg::term_t bt [12];
    flash_sector_pkg::term_t wt = '{1'b1, 16'hc000, 16'hff00};
    int num_errors = 0;
    int n_compared = 0;
    always #2 mclk_i = ~mclk_i;
    flash_sector_access #(.MAIN_AW(4), .BOOT_AW(3), .GAP_CYCLES(40), .PROG_CYCLES(4),
        .DEVICE_ID(ID)) u_dut (.mclk_i, .reset_i, .bus_i(bus), .main_terms_i(mt),
        .boot_terms_i(bt), .window_term_i(wt), .main_protect_i(mp), .boot_protect_i(4'h5),
        .security_i(sec), .status_pin_en_i(en), .rdata_o(rdat), .rvalid_o(vld),
        .main_sector_select_o(msel), .boot_sector_select_o(bsel), .register_window_select_o(),
        .port_c_pin_three_o(pin), .port_c_pin_three_oe_n_o(oe_n));
    flash_host_model h (.mclk_i, .rdata_i(rdat), .rvalid_i(vld), .ready_i(pin), .bus_o(bus));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic close_out();
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        h.rd(a, d);
        chk(d, e);
    endtask : rdchk
    task automatic wrdy();
        h.wait_ready(ok);
        if (!ok) begin
            num_errors++;
            $display("ERROR t=%0t ready=%h exp=%h", $time, ok, 1'b1);
            close_out();
        end
    endtask : wrdy
    task automatic cmd(input logic [7:0] c, input logic [15:0] b);
        h.wr(b | 16'h0555, 8'haa);
        h.wr(b | 16'h0aaa, 8'h55);
        h.wr(b | 16'h0555, c);
    endtask : cmd
    task automatic t_program();
        cmd(8'ha0, 16'h1000);
        h.wr(16'h1003, 8'h3c);
        @(negedge mclk_i);
        chk(8'(pin), 8'h00);
        wrdy();
        h.wr(16'h1003, 8'h00);
        rdchk(16'h1003, 8'h3c);
        cmd(8'ha0, 16'h0000);
        h.wr(16'h0005, 8'ha5);
        wrdy();
        rdchk(16'hd005, 8'ha5);
        chk(msel, 8'h01);
        h.wr(16'h9001, 8'h00);
        chk({4'h0, bsel}, 8'h02);
        cmd(8'ha0, 16'h6000);
        h.wr(16'h6001, 8'h11);
        repeat (2) @(negedge mclk_i);
        chk(8'(pin), 8'h01);
    endtask : t_program
    task automatic t_erase();
        cmd(8'h80, 16'h1000);
        cmd(8'h30, 16'h1000);
        repeat (44) @(negedge mclk_i); // Gap runs out, erase under way
        chk(8'(pin), 8'h00);
        h.wr(16'h1000, 8'hb0);
        @(negedge mclk_i);
        chk(8'(pin), 8'h01);
        rdchk(16'h0005, 8'ha5);
        h.wr(16'h1000, 8'h30);
        wrdy();
        rdchk(16'h1003, 8'hff);
        rdchk(16'h0005, 8'ha5);
    endtask : t_erase
    task automatic t_abort();
        for (int k = 0; k < 2; k++) begin
            h.wr(16'h2555, 8'haa);
            h.wr(16'h2aaa, 8'h55);
            if (k == 0) h.wr(16'h2555, 8'h12);
            else repeat (45) @(negedge mclk_i);
            h.wr(16'h2555, 8'ha0);
            h.wr(16'h2009, 8'h77);
            repeat (2) @(negedge mclk_i);
            chk(8'(pin), 8'h01);
        end
    endtask : t_abort
    task automatic t_id();
        cmd(8'h90, 16'h1000);
        rdchk(16'h1001, ID);
        rdchk(16'h6002, 8'h01);
        rdchk(16'ha002, 8'h01);
        rdchk(16'h1002, 8'h00);
        h.wr(16'h1000, 8'hf0);
        rdchk(16'h1003, 8'hff);
    endtask : t_id
    initial begin
        foreach (mt[i]) mt[i] = '{i % 3 == 0, 16'(i / 3 * 4096), 16'hf000};
        foreach (bt[i]) bt[i] = '{i % 3 == 0, 16'(32'h8000 + i / 3 * 4096), 16'hf000};
        mt[1] = '{1'b1, 16'hd000, 16'hf000};
        repeat (5) @(negedge mclk_i);
        reset_i = 1'b0;
        en = 1'b1;
        repeat (2) @(negedge mclk_i);
        chk({6'h0, pin, oe_n}, 8'h02);
        h.wr(16'hc0c0, 8'hff);
        rdchk(16'hc0c0, 8'h40);
        rdchk(16'hc0c2, 8'h85);
        rdchk(16'hc0c1, 8'h00);
        mp = 8'h41;
        sec = 1'b0;
        rdchk(16'hc0c0, 8'h41);
        rdchk(16'hc0c2, 8'h05);
        mp = 8'h40;
        sec = 1'b1;
        t_program();
        t_abort();
        t_erase();
        t_id();
        close_out();
    end
endmodule : flash_sector_access_tb
